// ---- verilog/pid_map.vh ----
// Constants for the packed integer datapath and its load aligner.
// Assumes inclusion by bare name from every design file of the block.
`ifndef PID_MAP_VH
`define PID_MAP_VH

// Operation codes
`define PID_OP_MUL 3'h0
`define PID_OP_ADD 3'h1
`define PID_OP_SUB 3'h2
`define PID_OP_SHL 3'h3
`define PID_OP_SHR 3'h4
`define PID_OP_MADD 3'h5
`define PID_OP_CMUL 3'h6

// Field layout
`define PID_REG_W 128
`define PID_LANE_W 64
`define PID_ELEM_W 32
`define PID_WORD_W 16
`define PID_SHIFT_MAX 8'h0f
`define PID_BLK_BYTES 16
`define PID_OFF_W 4

// Result latency in clock cycles
`define PID_RES_LAT 1

// Pending store table depth
`define PID_ST_DEPTH 4

// Aligner states, one-hot
`define PID_AL_IDLE 4'h1
`define PID_AL_LO 4'h2
`define PID_AL_HI 4'h4
`define PID_AL_OUT 4'h8

`endif

// ---- verilog/pid_align_load.v ----
// Load aligner for the special unaligned 128-bit load.
// Assumes a memory port that returns one aligned 16-byte block per
// request, answering with a one-cycle valid while the request stands.
`timescale 1ns/10ps
`default_nettype none
`include "pid_map.vh"

module pid_align_load #(
  parameter AW = 32
) (
  input wire clk_in, // Core clock
  input wire sys_rst_in, // Sync reset, high
  input wire req_valid_in, // Load request
  input wire [AW-1:0] req_addr_in, // Byte address
  output wire req_ready_out, // Idle, may take request
  output reg data_valid_out, // One-cycle result strobe
  output reg [127:0] data_out, // Extracted 16 bytes
  output wire mem_req_out, // Block read request
  output wire [AW-1:0] mem_addr_out, // Aligned block address
  input wire [127:0] mem_rdata_in, // Block data
  input wire mem_rvalid_in // Block data valid
);

  // ****************************************
  // State and captured request
  // ****************************************
  reg [3:0] state_r;
  reg [3:0] state_nxt;
  reg [AW-1:0] base_r;
  reg [3:0] off_r;
  reg [127:0] lo_r;
  wire [255:0] pair;
  wire [255:0] shifted;
  // Block stride sized to the address so the sum never widens
  localparam [AW-1:0] BLK_STEP = `PID_BLK_BYTES;

  assign req_ready_out = (state_r == `PID_AL_IDLE);
  assign mem_req_out = (state_r == `PID_AL_LO) || (state_r == `PID_AL_HI);
  // Second block is the next aligned one
  assign mem_addr_out = (state_r == `PID_AL_HI) ?
                        base_r + BLK_STEP : base_r;
  // Low block in the low half, so a right shift walks forward in memory
  assign pair = {mem_rdata_in, lo_r};
  assign shifted = pair >> {off_r, 3'h0};

  always @* begin
    state_nxt = state_r;
    case (state_r)
      `PID_AL_IDLE: begin
        if (req_valid_in) begin
          state_nxt = `PID_AL_LO;
        end
      end
      `PID_AL_LO: begin
        if (mem_rvalid_in) begin
          // Aligned address needs the one block only
          state_nxt = (off_r == 4'h0) ? `PID_AL_OUT : `PID_AL_HI;
        end
      end
      `PID_AL_HI: begin
        if (mem_rvalid_in) begin
          state_nxt = `PID_AL_OUT;
        end
      end
      `PID_AL_OUT: begin
        state_nxt = `PID_AL_IDLE;
      end
      default: begin
        state_nxt = `PID_AL_IDLE;
      end
    endcase
  end

  // ****************************************
  // Capture and extraction
  // ****************************************
  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      state_r <= `PID_AL_IDLE;
      base_r <= {AW{1'b0}};
      off_r <= 4'h0;
      lo_r <= 128'h0;
      data_valid_out <= 1'b0;
      data_out <= 128'h0;
    end else begin
      state_r <= state_nxt;
      data_valid_out <= 1'b0;
      if (state_r == `PID_AL_IDLE && req_valid_in) begin
        base_r <= {req_addr_in[AW-1:4], 4'h0};
        off_r <= req_addr_in[3:0];
      end
      if (state_r == `PID_AL_LO && mem_rvalid_in) begin
        lo_r <= mem_rdata_in;
        if (off_r == 4'h0) begin
          data_out <= mem_rdata_in;
          data_valid_out <= 1'b1;
        end
      end
      if (state_r == `PID_AL_HI && mem_rvalid_in) begin
        data_out <= shifted[127:0];
        data_valid_out <= 1'b1;
      end
    end
  end

endmodule
`default_nettype wire

// ---- verilog/pid_datapath.v ----
// Packed integer datapath: lane multiply, quad add/sub, byte shifts,
// word multiply-add and complex multiply, plus the special-load aligner
// and a store-to-load overlap stall check.
// Assumes operands from the register file and in-order store retirement.
`timescale 1ns/10ps
`default_nettype none
`include "pid_map.vh"

module pid_datapath #(
  parameter AW = 32,
  parameter ST_DEPTH = `PID_ST_DEPTH
) (
  input wire clk_in, // Core clock
  input wire sys_rst_in, // Sync reset, high
  input wire op_valid_in, // Operands valid
  input wire [2:0] op_code_in, // Operation select
  input wire op_wide_in, // 1: 128-bit form
  input wire [127:0] src_a_in, // First operand
  input wire [127:0] src_b_in, // Second operand
  input wire [7:0] imm_in, // Shift byte count
  output reg res_valid_out, // Result strobe
  output reg [127:0] res_data_out, // Result
  input wire uload_valid_in, // Special load request
  input wire [AW-1:0] uload_addr_in, // Special load address
  output wire uload_ready_out, // Aligner idle
  output wire uload_valid_out, // Special load data strobe
  output wire [127:0] uload_data_out, // Special load data
  output wire mem_req_out, // Block read request
  output wire [AW-1:0] mem_addr_out, // Block address
  input wire [127:0] mem_rdata_in, // Block data
  input wire mem_rvalid_in, // Block data valid
  input wire st_valid_in, // Store entering queue
  input wire [AW-1:0] st_addr_in, // Store byte address
  input wire [2:0] st_size_in, // Store size, log2 bytes
  output wire st_ready_out, // Store table not full
  input wire st_drain_in, // Oldest store written
  input wire ld_chk_valid_in, // Load to check
  input wire [AW-1:0] ld_chk_addr_in, // Load byte address
  input wire [2:0] ld_chk_size_in, // Load size, log2 bytes
  output wire ld_stall_out // Load must wait
);

  localparam PW = (ST_DEPTH > 1) ? $clog2(ST_DEPTH) : 1;

  // ****************************************
  // Operation decode
  // ****************************************
  wire op_shl;
  wire op_shr;
  wire op_cmul;
  wire hi_lane_on;

  assign op_shl = (op_code_in == `PID_OP_SHL);
  assign op_shr = (op_code_in == `PID_OP_SHR);
  assign op_cmul = (op_code_in == `PID_OP_CMUL);
  // Byte shifts always span the whole register, whatever the form bit
  assign hi_lane_on = op_wide_in | op_shl | op_shr;

  // ****************************************
  // Lane multiply, add and subtract
  // ****************************************
  wire [63:0] mul_lane [0:1];
  wire [63:0] add_lane [0:1];
  wire [63:0] sub_lane [0:1];
  wire [127:0] cm_a;
  wire [127:0] madd_a;
  wire [31:0] madd_word [0:3];

  genvar gl;
  generate
    for (gl = 0; gl < 2; gl = gl + 1) begin : g_lane
      wire [63:0] a_lane;
      wire [63:0] b_lane;
      assign a_lane = src_a_in[gl*64 +: 64];
      assign b_lane = src_b_in[gl*64 +: 64];
      // Low element of each lane only, full width kept
      assign mul_lane[gl] = a_lane[31:0] * b_lane[31:0];
      // Plain modular arithmetic serves both signednesses
      assign add_lane[gl] = a_lane + b_lane;
      assign sub_lane[gl] = a_lane - b_lane;
    end
  endgenerate

  // ****************************************
  // Word multiply-add and complex multiply
  // ****************************************
  // Low dwords duplicated: [Dr Di Dr Di] per lane
  assign cm_a = {src_a_in[63:32], src_a_in[63:32],
                 src_a_in[31:0], src_a_in[31:0]};
  assign madd_a = op_cmul ? cm_a : src_a_in;

  genvar gw;
  generate
    for (gw = 0; gw < 4; gw = gw + 1) begin : g_word
      wire signed [15:0] a_lo;
      wire signed [15:0] a_hi;
      wire signed [15:0] b_lo;
      wire signed [15:0] b_hi;
      wire signed [31:0] p_lo;
      wire signed [31:0] p_hi;
      // Low word of each doubleword pairs with low, high with high
      assign a_lo = madd_a[gw*32 +: 16];
      assign a_hi = madd_a[gw*32+16 +: 16];
      assign b_lo = src_b_in[gw*32 +: 16];
      assign b_hi = src_b_in[gw*32+16 +: 16];
      assign p_lo = a_lo * b_lo;
      assign p_hi = a_hi * b_hi;
      // Only the all-minimum case wraps, as the sum is kept at 32 bits
      assign madd_word[gw] = p_lo + p_hi;
    end
  endgenerate

  // ****************************************
  // Whole-register byte shifts
  // ****************************************
  wire shift_clear;
  wire [6:0] shift_bits;
  wire [127:0] shl_raw;
  wire [127:0] shr_raw;
  wire [127:0] shl_res;
  wire [127:0] shr_res;

  // Only the low four bits steer the shifter; larger counts clear
  assign shift_clear = (imm_in > `PID_SHIFT_MAX);
  assign shift_bits = {imm_in[3:0], 3'h0};
  // Logical shifts bring in zeros at the vacated end
  assign shl_raw = src_a_in << shift_bits;
  assign shr_raw = src_a_in >> shift_bits;
  assign shl_res = shift_clear ? 128'h0 : shl_raw;
  assign shr_res = shift_clear ? 128'h0 : shr_raw;

  // ****************************************
  // Result select and output stage
  // ****************************************
  wire [127:0] res_nxt;
  wire [127:0] shift_res;

  // One shift result serves both lanes; the clear is applied inside it
  assign shift_res = op_shl ? shl_res : shr_res;

  genvar gr;
  generate
    for (gr = 0; gr < 2; gr = gr + 1) begin : g_res
      reg [63:0] lane_nxt;
      wire lane_on;
      // Upper lane is forced to zero in the 64-bit form, except for the byte shifts
      assign lane_on = (gr == 0) || hi_lane_on;
      always @* begin
        lane_nxt = 64'h0;
        case (op_code_in)
          `PID_OP_MUL: begin
            lane_nxt = mul_lane[gr];
          end
          `PID_OP_ADD: begin
            lane_nxt = add_lane[gr];
          end
          `PID_OP_SUB: begin
            lane_nxt = sub_lane[gr];
          end
          `PID_OP_SHL: begin
            lane_nxt = shift_res[gr*64 +: 64];
          end
          `PID_OP_SHR: begin
            lane_nxt = shift_res[gr*64 +: 64];
          end
          `PID_OP_MADD, `PID_OP_CMUL: begin
            lane_nxt = {madd_word[gr*2+1], madd_word[gr*2]};
          end
          default: begin
            lane_nxt = 64'h0;
          end
        endcase
      end
      // Undefined codes fall to zero through the default branch
      assign res_nxt[gr*64 +: 64] = lane_on ? lane_nxt : 64'h0;
    end
  endgenerate

  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      res_valid_out <= 1'b0;
      res_data_out <= 128'h0;
    end else begin
      res_valid_out <= op_valid_in;
      // Result holds between ops, so the consumer may read it late
      if (op_valid_in) begin
        res_data_out <= res_nxt;
      end
    end
  end

  // ****************************************
  // Special unaligned load
  // ****************************************
  pid_align_load #(
    .AW(AW)
  ) u_align (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .req_valid_in(uload_valid_in),
    .req_addr_in(uload_addr_in),
    .req_ready_out(uload_ready_out),
    .data_valid_out(uload_valid_out),
    .data_out(uload_data_out),
    .mem_req_out(mem_req_out),
    .mem_addr_out(mem_addr_out),
    .mem_rdata_in(mem_rdata_in),
    .mem_rvalid_in(mem_rvalid_in)
  );

  // ****************************************
  // Pending store table
  // ****************************************
  // Stores retire in order, so the table is a ring of flip-flops
  reg [ST_DEPTH-1:0] st_vld_r;
  reg [AW-1:0] st_addr_r [0:ST_DEPTH-1];
  reg [2:0] st_size_r [0:ST_DEPTH-1];
  reg [PW-1:0] wr_ptr_r;
  reg [PW-1:0] rd_ptr_r;
  wire st_push;
  wire st_pop;
  wire [PW-1:0] wr_ptr_inc;
  wire [PW-1:0] rd_ptr_inc;
  wire wr_wrap;
  wire rd_wrap;

  // A full table refuses pushes even while the oldest entry drains
  assign st_ready_out = ~st_vld_r[wr_ptr_r];
  assign st_push = st_valid_in & st_ready_out;
  assign st_pop = st_drain_in & st_vld_r[rd_ptr_r];
  assign wr_wrap = (wr_ptr_r == ST_DEPTH - 1);
  assign rd_wrap = (rd_ptr_r == ST_DEPTH - 1);
  // Explicit wrap keeps non-power-of-two depths in range
  assign wr_ptr_inc = wr_wrap ? {PW{1'b0}} : wr_ptr_r + 1'b1;
  assign rd_ptr_inc = rd_wrap ? {PW{1'b0}} : rd_ptr_r + 1'b1;

  integer i;
  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      st_vld_r <= {ST_DEPTH{1'b0}};
      wr_ptr_r <= {PW{1'b0}};
      rd_ptr_r <= {PW{1'b0}};
      for (i = 0; i < ST_DEPTH; i = i + 1) begin
        st_addr_r[i] <= {AW{1'b0}};
        st_size_r[i] <= 3'h0;
      end
    end else begin
      if (st_pop) begin
        st_vld_r[rd_ptr_r] <= 1'b0;
        rd_ptr_r <= rd_ptr_inc;
      end
      // A push lands in a free slot, never the one being drained
      if (st_push) begin
        st_vld_r[wr_ptr_r] <= 1'b1;
        st_addr_r[wr_ptr_r] <= st_addr_in;
        st_size_r[wr_ptr_r] <= st_size_in;
        wr_ptr_r <= wr_ptr_inc;
      end
    end
  end

  // ****************************************
  // Store-to-load overlap check
  // ****************************************
  wire [4:0] ld_bytes;
  wire [AW:0] ld_end;
  wire [ST_DEPTH-1:0] hit;

  // Sizes above 16 bytes are not expected; the byte count would wrap
  assign ld_bytes = 5'h01 << ld_chk_size_in;
  assign ld_end = {1'b0, ld_chk_addr_in} + {{(AW-4){1'b0}}, ld_bytes};

  genvar gs;
  generate
    for (gs = 0; gs < ST_DEPTH; gs = gs + 1) begin : g_st
      wire [4:0] s_bytes;
      wire [AW:0] s_end;
      wire ld_lo_ok;
      wire st_lo_ok;
      wire same_start;
      wire not_wider;
      wire overlap;
      wire fwd_ok;
      assign s_bytes = 5'h01 << st_size_r[gs];
      assign s_end = {1'b0, st_addr_r[gs]} +
                     {{(AW-4){1'b0}}, s_bytes};
      // Two half-open byte ranges meet when each starts before the other ends
      assign ld_lo_ok = ({1'b0, ld_chk_addr_in} < s_end);
      assign st_lo_ok = ({1'b0, st_addr_r[gs]} < ld_end);
      assign overlap = ld_lo_ok && st_lo_ok;
      assign same_start = (ld_chk_addr_in == st_addr_r[gs]);
      assign not_wider = (ld_chk_size_in <= st_size_r[gs]);
      // Only a same-start load no wider than the store can forward
      assign fwd_ok = same_start && not_wider;
      assign hit[gs] = st_vld_r[gs] & overlap & ~fwd_ok;
    end
  endgenerate

  // Conservative: stalls until every conflicting store drains
  assign ld_stall_out = ld_chk_valid_in & (|hit);

endmodule
`default_nettype wire

// ---- bench/pid_mem_model.sv ----
// Memory stand-in answering aligned 16-byte block reads.
// Assumes each request is held until its one-cycle answer.
`timescale 1ns/10ps
`default_nettype none
module pid_mem_model (
  input wire logic clk_in, // Core clock
  input wire logic sys_rst_in, // Sync reset, high
  input wire logic req_in, // Block request
  input wire logic [31:0] addr_in, // Block address
  input wire logic [1:0] wait_in, // Extra answer delay
  output logic [127:0] rdata_out, // Block data
  output logic rvalid_out // Data strobe
);
  logic [1:0] cnt_r;
  logic [31:0] x;
  initial rdata_out = 128'h0;
  // ****************
  // Answer logic
  // ****************
  always @(posedge clk_in) begin
    rdata_out <= ~rdata_out; // Stale data must never look valid
    rvalid_out <= 1'b0;
    cnt_r <= 2'h0;
    if (!sys_rst_in && req_in && !rvalid_out) begin
      cnt_r <= cnt_r + 2'h1;
      if (cnt_r == wait_in) begin
        rvalid_out <= 1'b1;
        for (int n = 0; n < 16; n++) begin
          x = addr_in + n;
          rdata_out[8*n+:8] <= x[7:0] ^ x[15:8] ^ 8'h5a;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ---- bench/pid_datapath_sva.sv ----
// Port checker for the packed integer datapath.
// Assumes one core clock and a synchronous high reset.
`timescale 1ns/10ps
`default_nettype none
`include "pid_map.vh"
module pid_datapath_sva #(
  parameter AW = 32,
  parameter ST_DEPTH = 4
) (
  input wire logic clk_in, // Core clock
  input wire logic sys_rst_in, // Sync reset
  input wire logic op_valid_in, // Operands valid
  input wire logic [2:0] op_code_in, // Operation
  input wire logic op_wide_in, // Wide form
  input wire logic [7:0] imm_in, // Shift count
  input wire logic res_valid_out, // Result strobe
  input wire logic [127:0] res_data_out, // Result
  input wire logic uload_valid_in, // Load request
  input wire logic uload_ready_out, // Aligner idle
  input wire logic uload_valid_out, // Load data strobe
  input wire logic mem_req_out, // Block request
  input wire logic [AW-1:0] mem_addr_out, // Block address
  input wire logic mem_rvalid_in, // Block valid
  input wire logic ld_chk_valid_in, // Load to check
  input wire logic ld_stall_out // Load stall
);
  // ****************
  // Properties
  // ****************
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  sequence s_take;
    uload_valid_in && uload_ready_out;
  endsequence
  sequence s_fetch;
    !uload_ready_out && mem_req_out;
  endsequence
  property p_res_lat;
    op_valid_in |=> res_valid_out;
  endproperty
  property p_res_idle;
    !op_valid_in |=> !res_valid_out;
  endproperty
  property p_half;
    op_valid_in && !op_wide_in && op_code_in < `PID_OP_SHL |=> res_data_out[127:64] == 64'h0;
  endproperty
  property p_shift_zero;
    op_valid_in && (op_code_in == `PID_OP_SHL || op_code_in == `PID_OP_SHR)
      && imm_in > `PID_SHIFT_MAX |=> res_data_out == 128'h0;
  endproperty
  property p_fill;
    op_valid_in && imm_in != 8'h0 && (op_code_in == `PID_OP_SHL || op_code_in == `PID_OP_SHR)
      |=> (($past(op_code_in) == `PID_OP_SHL) ? res_data_out[7:0] : res_data_out[127:120]) == 8'h0;
  endproperty
  property p_mem_base;
    mem_req_out |-> mem_addr_out[3:0] == 4'h0;
  endproperty
  property p_mem_hold;
    mem_req_out && !mem_rvalid_in |=> mem_req_out && $stable(mem_addr_out);
  endproperty
  property p_load_go;
    s_take |=> s_fetch;
  endproperty
  property p_load_time;
    s_take |-> ##[2:20] uload_valid_out;
  endproperty
  property p_load_end;
    uload_valid_out |=> uload_ready_out;
  endproperty
  property p_no_chk;
    !ld_chk_valid_in |-> !ld_stall_out;
  endproperty
  a_res_lat: assert property (p_res_lat) else $error("result strobe missing");
  a_res_idle: assert property (p_res_idle) else $error("spurious result strobe");
  a_half: assert property (p_half) else $error("narrow form upper lane not zero");
  a_shift_zero: assert property (p_shift_zero) else $error("large shift not zero");
  a_fill: assert property (p_fill) else $error("vacated byte not zero");
  a_mem_base: assert property (p_mem_base) else $error("block address unaligned");
  a_mem_hold: assert property (p_mem_hold) else $error("block request dropped");
  a_load_go: assert property (p_load_go) else $error("load not started");
  a_load_time: assert property (p_load_time) else $error("load data late");
  a_load_end: assert property (p_load_end) else $error("aligner not idle");
  a_no_chk: assert property (p_no_chk) else $error("stall without load");
endmodule
bind pid_datapath pid_datapath_sva #(.AW(AW), .ST_DEPTH(ST_DEPTH)) chk_u (.clk_in, .sys_rst_in,
  .op_valid_in, .op_code_in, .op_wide_in, .imm_in, .res_valid_out, .res_data_out,
  .uload_valid_in, .uload_ready_out, .uload_valid_out, .mem_req_out, .mem_addr_out,
  .mem_rvalid_in, .ld_chk_valid_in, .ld_stall_out);
`default_nettype wire

// ---- bench/test_pid_datapath.sv ----
// Self-checking bench for the packed integer datapath.
// Assumes the memory stand-in and the bound checker are compiled with it.
`timescale 1ns/10ps
`default_nettype none
`include "pid_map.vh"
`define CHK(nm, e, s) begin samples_checked++; if ((s) !== (e)) begin errors++; \
  $display("MISMATCH %s exp %h got %h", nm, e, s); end end
module test_pid_datapath;
  logic clk_in = 0, sys_rst_in = 1, op_valid_in = 0, op_wide_in = 0, uload_valid_in = 0;
  logic st_valid_in = 0, st_drain_in = 0, ld_chk_valid_in = 0;
  logic [2:0] op_code_in = 0, st_size_in = 0, ld_chk_size_in = 0;
  logic [127:0] src_a_in = 0, src_b_in = 0, e_v;
  logic [7:0] imm_in = 0;
  logic [7:0] cor[5] = '{8'h0, 8'h1, 8'hf, 8'h10, 8'hff};
  logic [31:0] uload_addr_in = 0, st_addr_in = 0, ld_chk_addr_in = 0, seed = 32'h7007, r;
  logic [1:0] mem_wait = 0;
  wire logic res_valid_out, uload_ready_out, uload_valid_out, mem_req_out, mem_rvalid_in;
  wire logic st_ready_out, ld_stall_out;
  wire logic [127:0] res_data_out, uload_data_out, mem_rdata_in;
  wire logic [31:0] mem_addr_out;
  int errors = 0, samples_checked = 0, cycles = 0;
  logic [127:0] exp_q[$];
  logic [31:0] req_q[$], sa_q[$];
  int ss_q[$];
  pid_datapath #(.AW(32), .ST_DEPTH(4)) dut_u (.clk_in, .sys_rst_in, .op_valid_in, .op_code_in,
    .op_wide_in, .src_a_in, .src_b_in, .imm_in, .res_valid_out, .res_data_out, .uload_valid_in,
    .uload_addr_in, .uload_ready_out, .uload_valid_out, .uload_data_out, .mem_req_out,
    .mem_addr_out, .mem_rdata_in, .mem_rvalid_in, .st_valid_in, .st_addr_in, .st_size_in,
    .st_ready_out, .st_drain_in, .ld_chk_valid_in, .ld_chk_addr_in, .ld_chk_size_in,
    .ld_stall_out);
  pid_mem_model mem_u (.clk_in, .sys_rst_in, .req_in(mem_req_out), .addr_in(mem_addr_out),
    .wait_in(mem_wait), .rdata_out(mem_rdata_in), .rvalid_out(mem_rvalid_in));
  initial forever #50 clk_in = ~clk_in;
  // ****************
  // Reference model
  // ****************
  function automatic logic [31:0] lfsr();
    seed = {seed[30:0], ^(seed & 32'h80200003)};
    return seed;
  endfunction
  function automatic logic [127:0] exp_op(input logic [2:0] c, input logic w,
                                          input logic [127:0] a, b, input logic [7:0] im);
    logic [127:0] q;
    q = (c == 3'h6) ? {a[63:32], a[63:32], a[31:0], a[31:0]} : a;
    exp_op = 128'h0;
    case (c)
      3'h0: exp_op = {64'(a[95:64]) * b[95:64], 64'(a[31:0]) * b[31:0]};
      3'h1: exp_op = {a[127:64] + b[127:64], a[63:0] + b[63:0]};
      3'h2: exp_op = {a[127:64] - b[127:64], a[63:0] - b[63:0]};
      3'h3: exp_op = (im > 15) ? 128'h0 : a << (im * 8);
      3'h4: exp_op = (im > 15) ? 128'h0 : a >> (im * 8);
      3'h5, 3'h6: for (int k = 0; k < 4; k++) begin
        exp_op[32*k+:32] = $signed(q[32*k+:16]) * $signed(b[32*k+:16])
          + $signed(q[32*k+16+:16]) * $signed(b[32*k+16+:16]);
      end
      default: exp_op = 128'h0;
    endcase
    if (!w && c != 3'h3 && c != 3'h4) exp_op[127:64] = 64'h0;
  endfunction
  function automatic logic stall_exp(input logic [31:0] la, input int ls);
    longint unsigned s, l;
    stall_exp = 0;
    l = la;
    foreach (sa_q[i]) begin
      s = sa_q[i];
      if (l < s + (1 << ss_q[i]) && s < l + (1 << ls) && !(l == s && ls <= ss_q[i]))
        stall_exp = 1;
    end
  endfunction
  // ****************
  // Drivers and monitors
  // ****************
  task automatic finish_test();
    if (errors == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic dp(input logic v, input logic [2:0] c, input logic w,
                    input logic [127:0] a, b, input logic [7:0] im);
    op_valid_in = v; op_code_in = c; op_wide_in = w; src_a_in = a; src_b_in = b; imm_in = im;
    @(negedge clk_in);
  endtask
  task automatic uld(input logic [31:0] ad, input logic [1:0] wt);
    logic [127:0] e;
    logic [31:0] x;
    int n;
    mem_wait = wt;
    req_q.delete();
    for (int i = 0; i < 16; i++) begin
      x = ad + i;
      e[8*i+:8] = x[7:0] ^ x[15:8] ^ 8'h5a;
    end
    uload_valid_in = 1; uload_addr_in = ad;
    @(negedge clk_in);
    uload_addr_in = ~ad; // Refused while the aligner is busy
    @(negedge clk_in);
    uload_valid_in = 0;
    n = 0;
    while (uload_valid_out !== 1'b1 && n < 40) begin
      @(negedge clk_in);
      n++;
    end
    `CHK("uload_data", e, uload_data_out)
    `CHK("req_count", (ad[3:0] == 4'h0) ? 1 : 2, req_q.size())
    `CHK("req_base", {ad[31:4], 4'h0}, req_q[0])
    if (ad[3:0] != 4'h0) `CHK("req_next", {ad[31:4], 4'h0} + 32'h10, req_q[1])
    @(negedge clk_in);
  endtask
  task automatic step(input logic v, d, input logic [31:0] a, input logic [2:0] s,
                      input logic lv, input logic [31:0] la, input logic [2:0] ls);
    logic f;
    st_valid_in = v; st_drain_in = d; st_addr_in = a; st_size_in = s;
    ld_chk_valid_in = lv; ld_chk_addr_in = la; ld_chk_size_in = ls;
    #10;
    f = sa_q.size() < 4;
    `CHK("st_ready", f, st_ready_out)
    `CHK("ld_stall", lv & stall_exp(la, ls), ld_stall_out)
    if (d && sa_q.size() > 0) begin
      void'(sa_q.pop_front());
      void'(ss_q.pop_front());
    end
    if (v && f) begin
      sa_q.push_back(a);
      ss_q.push_back(s);
    end
    @(negedge clk_in);
  endtask
  always @(posedge clk_in) begin
    if (!sys_rst_in && op_valid_in) exp_q.push_back(exp_op(op_code_in, op_wide_in, src_a_in,
      src_b_in, imm_in));
    if (mem_rvalid_in) req_q.push_back(mem_addr_out);
  end
  always @(posedge clk_in) if (++cycles > 6000) begin
    errors++;
    finish_test();
  end
  always @(negedge clk_in) if (!sys_rst_in) begin
    `CHK("res_valid", exp_q.size() > 0, res_valid_out)
    if (exp_q.size() > 0) begin
      e_v = exp_q.pop_front();
      `CHK("res_data", e_v, res_data_out)
    end
  end
  // ****************
  // Main sequence
  // ****************
  initial begin
    repeat (8) @(posedge clk_in);
    @(negedge clk_in);
    `CHK("reset", 4'ha, {uload_ready_out, res_valid_out, st_ready_out, mem_req_out})
    sys_rst_in = 0;
    dp(1, `PID_OP_ADD, 1, {128{1'b1}}, {2{64'h1}}, 8'h0);
    dp(1, `PID_OP_SUB, 1, 128'h0, {2{64'h1}}, 8'h0);
    dp(1, `PID_OP_MUL, 1, {128{1'b1}}, {128{1'b1}}, 8'h0);
    for (int k = 3; k < 5; k++) begin
      foreach (cor[i]) dp(1, k[2:0], 0, {lfsr(), lfsr(), lfsr(), lfsr()}, 0, cor[i]);
    end
    repeat (400) begin
      r = lfsr();
      dp(r[0] | r[1], r[4:2], r[5], {lfsr(), lfsr(), lfsr(), lfsr()},
        {lfsr(), lfsr(), lfsr(), lfsr()}, {3'h0, r[12:8]});
    end
    dp(0, 0, 0, 0, 0, 0);
    // Special loads never overlap pending stores
    for (int i = 0; i < 20; i++) begin
      r = lfsr();
      uld((i < 16) ? {r[31:4], i[3:0]} : 32'hffffffe9 + i, r[5:4]);
    end
    step(1, 0, 32'h40, 2, 0, 0, 0);
    step(1, 0, 32'h44, 2, 1, 32'h40, 3);
    step(1, 1, 32'h80, 3, 1, 32'h40, 3);
    step(0, 1, 0, 0, 1, 32'h82, 1);
    step(0, 1, 0, 0, 1, 32'h80, 0);
    repeat (300) begin
      r = lfsr();
      step(r[0], r[1] & r[2], {26'h0, r[8:3]}, r[10:9] + r[11], r[12], {26'h0, r[18:13]},
        r[20:19] + r[21]);
    end
    finish_test();
  end
endmodule
`default_nettype wire
